/* iahw_map.vh */
// iahw_map.vh: register indices, field positions, reset values and timing
// constants of the interrupt and halt wake-up controller.
// assumes inclusion by bare name from the design files only.
`ifndef IAHW_MAP_VH
`define IAHW_MAP_VH

// register indices; byte address is four times the index
`define IAHW_IDX_MAIN_CLK   8'h38
`define IAHW_IDX_INT_STAT   8'h3d
`define IAHW_IDX_PER_EN     8'h3e
`define IAHW_IDX_EXT_SENSE  8'h3f
`define IAHW_IDX_WAKE_PR    8'h49
`define IAHW_IDX_WAKE_CS    8'h4a

// reset values
`define IAHW_RST_WAKE_PR    8'hff
`define IAHW_RST_BYTE       8'h00

// field positions
`define IAHW_BIT_SLOW_SEL   0
`define IAHW_BIT_HALT_WAKE  0
`define IAHW_BIT_MEASURE    1
`define IAHW_BIT_WAKE_FLAG  2
`define IAHW_BIT_MASK       7
`define IAHW_POS_EXT_PEND   4

// clocking and timing
`define IAHW_CLK_MHZ        250
`define IAHW_SLOW_DIV       32
`define IAHW_WAKE_TICK_MUL  64
`define IAHW_RCSTRT_NS      1000

// vectors: trap at the top, further sources two bytes apart below it
`define IAHW_VEC_TOP        16'hfffc
`define IAHW_PUSH_LAST      2'h3

`endif

/* iahw_edge_latch.v */
// iahw_edge_latch.v: edge-latched request of one combined external source.
// assumes pins already synchronous to clk_i; clr_i is a one-cycle pulse.
`default_nettype none

module iahw_edge_latch #(
   parameter GRP = 2
) (
   input  wire           clk_i,
   input  wire           arst_n_i,
   input  wire [GRP-1:0] pins_i,
   input  wire [GRP-1:0] pin_en_i,
   input  wire           rise_i,
   input  wire           clr_i,
   output wire           pend_o
);

   reg  lvl_reg;
   reg  pend_reg;
   wire lvl;
   wire edge_hit;

   // a low enabled pin pulls the combined level low and blocks rising edges
   assign lvl      = &(pins_i | ~pin_en_i);
   assign edge_hit = rise_i ? (lvl & ~lvl_reg) : (~lvl & lvl_reg);
   assign pend_o   = pend_reg;

   // level history and sticky request; a new edge beats the clear
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lvl_reg  <= 1'b1;
         pend_reg <= 1'b0;
      end else begin
         lvl_reg <= lvl;
         if (edge_hit)
            pend_reg <= 1'b1;
         else if (clr_i)
            pend_reg <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* iahw_ctrl.v */
// iahw_ctrl.v: interrupt arbitration, service entry and return sequencing,
// slow clock enable and auto wake-up from halt, with a wishbone slave.
// assumes core strobes (instr_end, trap, return_from_handler, mask set/clear) are one-cycle
// pulses and wait/halt are levels, all synchronous to clk_i.
//
// Notes on behaviour
// - maskable requests serviced only when mask clear
// - reset sets the global mask
// - finish instruction, then push four core registers
// - service entry sets the global mask
// - load program counter with source vector
// - return pops registers and clears mask
// - fixed priority picks among simultaneous requests
// - any source wakes wait; halt-capable wake halt
// - trap enters handler regardless of mask
// - edge request latched, cleared on entry
// - low enabled pin blocks combined source
// - peripheral raises only if enabled and unmasked
// - write zero or status-then-associated access clears
// - slow select divides cpu clock by 32
// - wait during slow keeps divided clock
// - reset starts in normal run clocking
// - wake flag set by hardware, cleared on read
// - measure bit runs oscillator to capture input
// - halt-wake enable times halt then wakes
// - halt time is 64 times prescaler ticks plus start-up
// - prescaler write of zero is ignored
`default_nettype none
`include "iahw_map.vh"

module iahw_ctrl #(
   parameter NEXT        = 3,
   parameter GRP         = 2,
   parameter NPER        = 4,
   parameter [3:0] PER_HALT_CAP = 4'h0,
   parameter RC_DIV      = 8,
   parameter RCSTRT_NS   = `IAHW_RCSTRT_NS
) (
   input  wire                clk_i,
   input  wire                arst_n_i,
   // wishbone slave
   input  wire [9:0]          adr_i,
   input  wire [31:0]         dat_i,
   input  wire [3:0]          sel_i,
   input  wire                we_i,
   input  wire                cyc_i,
   input  wire                stb_i,
   output wire [31:0]         dat_o,
   output wire                ack_o,
   // core side
   input  wire                instr_end_i,
   input  wire                trap_i,
   input  wire                return_from_handler_i,
   input  wire                mask_set_i,
   input  wire                mask_clr_i,
   input  wire                wait_i,
   input  wire                halt_i,
   output wire                mask_o,
   output wire                push_o,
   output wire [1:0]          push_sel_o,
   output wire                pop_o,
   output wire [1:0]          pop_sel_o,
   output wire                pc_load_o,
   output wire [15:0]         program_counter_o,
   output wire                wake_o,
   output wire                cpu_ce_o,
   output wire                slow_wait_o,
   // sources
   input  wire [NEXT*GRP-1:0] ext_pins_i,
   input  wire [NEXT*GRP-1:0] ext_pin_en_i,
   input  wire [NPER-1:0]     per_set_i,
   input  wire [NPER-1:0]     per_assoc_i,
   // wake oscillator
   output wire                wake_osc_en_o,
   output wire                wake_osc_capture_o
);

   localparam NSRC = 2 + NEXT + NPER;
   localparam WSRC = NEXT + 1;
   localparam RCSTRT_CYC = (RCSTRT_NS * `IAHW_CLK_MHZ + 999) / 1000;
   localparam [1:0] SEQ_IDLE = 2'b00;
   localparam [1:0] SEQ_PUSH = 2'b01;
   localparam [1:0] SEQ_VEC  = 2'b10;
   localparam [1:0] SEQ_POP  = 2'b11;

   ////////////////////////////////////////////////////////////////////////
   // registers

   reg            ack_reg;
   reg  [7:0]     rd_reg;
   reg            slow_select_reg;
   reg  [7:0]     wake_prescale_reg;
   reg            wake_flag_reg;
   reg            wake_osc_measure_reg;
   reg            halt_wake_enable_reg;
   reg  [NPER-1:0] per_en_reg;
   reg  [NPER-1:0] per_flag_reg;
   reg  [NPER-1:0] per_arm_reg;
   reg  [NEXT-1:0] ext_rise_reg;
   reg            mask_reg;
   reg            trap_reg;
   reg            wake_pend_reg;
   reg  [1:0]     state_reg;
   reg  [1:0]     step_reg;
   reg  [3:0]     src_reg;
   reg            wake_out_reg;
   reg  [4:0]     slow_cnt_reg;
   reg            ce_reg;
   reg            slow_wait_reg;
   reg  [15:0]    rc_div_reg;
   reg            rc_sq_reg;
   reg            halt_prev_reg;
   reg            aw_run_reg;
   reg  [15:0]    aw_start_reg;
   reg  [13:0]    aw_tick_reg;

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   wire [7:0] idx  = adr_i[9:2];
   wire       req  = cyc_i & stb_i;
   wire       acc  = req & ack_reg;
   wire       wr   = acc & we_i & sel_i[0];
   wire       rd   = acc & ~we_i;
   wire [7:0] wd   = dat_i[7:0];
   wire       hit_stat  = idx == `IAHW_IDX_INT_STAT;
   wire       hit_wcs   = idx == `IAHW_IDX_WAKE_CS;
   wire       hit_sense = idx == `IAHW_IDX_EXT_SENSE;
   wire [NEXT-1:0] ext_pend;

   assign ack_o = ack_reg;
   assign dat_o = {24'h000000, rd_reg};

   // read mux; unmapped indices read as zero
   reg [7:0] rd_mux;
   always @* begin
      rd_mux = `IAHW_RST_BYTE;
      case (idx)
         `IAHW_IDX_MAIN_CLK:
            rd_mux[`IAHW_BIT_SLOW_SEL] = slow_select_reg;
         `IAHW_IDX_INT_STAT: begin
            rd_mux[NPER-1:0] = per_flag_reg;
            rd_mux[`IAHW_POS_EXT_PEND +: NEXT] = ext_pend;
            rd_mux[`IAHW_BIT_MASK] = mask_reg;
         end
         `IAHW_IDX_PER_EN:
            rd_mux[NPER-1:0] = per_en_reg;
         `IAHW_IDX_EXT_SENSE:
            rd_mux[NEXT-1:0] = ext_rise_reg;
         `IAHW_IDX_WAKE_PR:
            rd_mux = wake_prescale_reg;
         `IAHW_IDX_WAKE_CS: begin
            rd_mux[`IAHW_BIT_WAKE_FLAG] = wake_flag_reg;
            rd_mux[`IAHW_BIT_MEASURE]   = wake_osc_measure_reg;
            rd_mux[`IAHW_BIT_HALT_WAKE] = halt_wake_enable_reg;
         end
         default:
            rd_mux = `IAHW_RST_BYTE;
      endcase
   end

   // one wait state: ack in the cycle after the request, data with it
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_reg <= 1'b0;
         rd_reg  <= `IAHW_RST_BYTE;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (req & ~ack_reg)
            rd_reg <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external sources

   wire            entry = (state_reg == SEQ_VEC);
   wire [7:0]      sense_chg = wd ^ {{(8-NEXT){1'b0}}, ext_rise_reg};

   genvar g;
   generate
      for (g = 0; g < NEXT; g = g + 1) begin : g_ext
         iahw_edge_latch #(
            .GRP(GRP)
         ) u_latch (
            .clk_i    (clk_i),
            .arst_n_i (arst_n_i),
            .pins_i   (ext_pins_i[g*GRP +: GRP]),
            .pin_en_i (ext_pin_en_i[g*GRP +: GRP]),
            .rise_i   (ext_rise_reg[g]),
            .clr_i    ((entry & (src_reg == g + 1)) |
                       (wr & hit_sense & sense_chg[g])),
            .pend_o   (ext_pend[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // request vector and fixed priority, lowest index first

   wire            trap_now = trap_reg | trap_i;   // trap taken at its own boundary
   reg  [NSRC-1:0] raw;
   reg  [NSRC-1:0] halt_cap;
   reg  [3:0]      pick;
   reg             any_pick;
   integer         i;

   always @* begin
      raw = {NSRC{1'b0}};
      raw[0] = trap_now;
      raw[NEXT:1] = ext_pend;
      raw[WSRC] = wake_pend_reg;
      raw[NSRC-1:WSRC+1] = per_flag_reg & per_en_reg;
      halt_cap = {NSRC{1'b0}};
      halt_cap[NEXT:1] = {NEXT{1'b1}};
      halt_cap[WSRC] = 1'b1;
      halt_cap[NSRC-1:WSRC+1] = PER_HALT_CAP[NPER-1:0];
      pick = 4'h0;
      any_pick = trap_now;
      for (i = NSRC - 1; i > 0; i = i - 1) begin
         if (raw[i] & ~mask_reg) begin
            pick = i[3:0];
            any_pick = 1'b1;
         end
      end
      if (trap_now)
         pick = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // service entry and return sequencer

   assign push_o            = (state_reg == SEQ_PUSH);
   assign push_sel_o        = step_reg;
   assign pop_o             = (state_reg == SEQ_POP);
   assign pop_sel_o         = step_reg;
   assign pc_load_o         = entry;
   assign program_counter_o = `IAHW_VEC_TOP - {11'h000, src_reg, 1'b0};
   assign mask_o            = mask_reg;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= SEQ_IDLE;
         step_reg  <= 2'h0;
         src_reg   <= 4'h0;
         mask_reg  <= 1'b1;
      end else begin
         case (state_reg)
            SEQ_IDLE: begin
               step_reg <= 2'h0;
               if (return_from_handler_i)
                  state_reg <= SEQ_POP;
               else if (instr_end_i & any_pick) begin
                  src_reg   <= pick;
                  state_reg <= SEQ_PUSH;
               end else if (mask_set_i)
                  mask_reg <= 1'b1;
               else if (mask_clr_i)
                  mask_reg <= 1'b0;
            end
            SEQ_PUSH: begin
               step_reg <= step_reg + 2'h1;
               if (step_reg == `IAHW_PUSH_LAST)
                  state_reg <= SEQ_VEC;
            end
            SEQ_VEC: begin
               mask_reg  <= 1'b1;
               state_reg <= SEQ_IDLE;
            end
            SEQ_POP: begin
               step_reg <= step_reg + 2'h1;
               if (step_reg == `IAHW_PUSH_LAST) begin
                  mask_reg  <= 1'b0;
                  state_reg <= SEQ_IDLE;
               end
            end
            default:
               state_reg <= SEQ_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trap, peripheral flags and control registers

   wire [NPER-1:0] per_wr_clr = (wr & hit_stat) ? ~wd[NPER-1:0] : {NPER{1'b0}};
   wire [NPER-1:0] per_seq_clr = per_arm_reg & per_assoc_i;
   wire            stat_acc = acc & hit_stat;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trap_reg        <= 1'b0;
         per_flag_reg    <= {NPER{1'b0}};
         per_arm_reg     <= {NPER{1'b0}};
         per_en_reg      <= {NPER{1'b0}};
         ext_rise_reg    <= {NEXT{1'b0}};
         slow_select_reg <= 1'b0;
      end else begin
         if (trap_i)
            trap_reg <= 1'b1;
         else if (entry & (src_reg == 4'h0))
            trap_reg <= 1'b0;
         // new event wins over either clearing path
         per_flag_reg <= per_set_i |
                         (per_flag_reg & ~per_wr_clr & ~per_seq_clr);
         if (stat_acc)
            per_arm_reg <= per_flag_reg;
         else
            per_arm_reg <= per_arm_reg & ~per_assoc_i & per_flag_reg;
         if (wr & (idx == `IAHW_IDX_PER_EN))
            per_en_reg <= wd[NPER-1:0];
         if (wr & hit_sense)
            ext_rise_reg <= wd[NEXT-1:0];
         if (wr & (idx == `IAHW_IDX_MAIN_CLK))
            slow_select_reg <= wd[`IAHW_BIT_SLOW_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cpu clock enable and wake request

   assign cpu_ce_o    = ce_reg;
   assign slow_wait_o = slow_wait_reg;
   assign wake_o      = wake_out_reg;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         slow_cnt_reg  <= 5'h00;
         ce_reg        <= 1'b1;
         slow_wait_reg <= 1'b0;
         wake_out_reg  <= 1'b0;
      end else begin
         slow_cnt_reg  <= slow_cnt_reg + 5'h01;
         ce_reg        <= ~slow_select_reg |
                          (slow_cnt_reg == `IAHW_SLOW_DIV - 1);
         slow_wait_reg <= slow_select_reg & wait_i;
         wake_out_reg  <= (wait_i & |raw) |
                          (halt_i & |(raw & halt_cap));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wake oscillator divider and halt timer

   wire        osc_on  = wake_osc_measure_reg | aw_run_reg;
   wire        rc_tick = osc_on & (rc_div_reg == RC_DIV - 1);
   wire [13:0] aw_last = {wake_prescale_reg, 6'h00} - 14'h0001;
   wire        aw_fire = aw_run_reg & (aw_start_reg == 16'h0000) & rc_tick &
                         (aw_tick_reg == aw_last);
   wire        wcs_rd  = rd & hit_wcs;

   assign wake_osc_en_o      = osc_on;
   assign wake_osc_capture_o = wake_osc_measure_reg & rc_sq_reg;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rc_div_reg    <= 16'h0000;
         rc_sq_reg     <= 1'b0;
         halt_prev_reg <= 1'b0;
         aw_run_reg    <= 1'b0;
         aw_start_reg  <= 16'h0000;
         aw_tick_reg   <= 14'h0000;
      end else begin
         halt_prev_reg <= halt_i;
         if (!osc_on | rc_tick)
            rc_div_reg <= 16'h0000;
         else
            rc_div_reg <= rc_div_reg + 16'h0001;
         if (rc_tick)
            rc_sq_reg <= ~rc_sq_reg;
         if (halt_i & ~halt_prev_reg & halt_wake_enable_reg) begin
            aw_run_reg   <= 1'b1;
            aw_start_reg <= RCSTRT_CYC[15:0];
            aw_tick_reg  <= 14'h0000;
         end else if (!halt_i | aw_fire)
            aw_run_reg <= 1'b0;
         else if (aw_start_reg != 16'h0000)
            aw_start_reg <= aw_start_reg - 16'h0001;
         else if (rc_tick)
            aw_tick_reg <= aw_tick_reg + 14'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wake registers: flag sticky, clear on read, set wins

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_prescale_reg    <= `IAHW_RST_WAKE_PR;
         wake_flag_reg        <= 1'b0;
         wake_osc_measure_reg <= 1'b0;
         halt_wake_enable_reg <= 1'b0;
         wake_pend_reg        <= 1'b0;
      end else begin
         if (wr & (idx == `IAHW_IDX_WAKE_PR) & (wd != 8'h00))
            wake_prescale_reg <= wd;
         if (aw_fire)
            wake_flag_reg <= 1'b1;
         else if (wcs_rd)
            wake_flag_reg <= 1'b0;
         if (wr & hit_wcs) begin
            wake_osc_measure_reg <= wd[`IAHW_BIT_MEASURE];
            halt_wake_enable_reg <= wd[`IAHW_BIT_HALT_WAKE];
         end
         if (aw_fire)
            wake_pend_reg <= 1'b1;
         else if (entry & (src_reg == WSRC))
            wake_pend_reg <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* iahw_checker.sv */
// iahw_checker.sv: assertions on the ports of the interrupt and halt wake-up controller.
// assumes it is bound to iahw_ctrl and sees its ports by name.
`default_nettype none

module iahw_checker (
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic        trap_i,
   input wire logic        wait_i,
   input wire logic        halt_i,
   input wire logic        mask_o,
   input wire logic        push_o,
   input wire logic [1:0]  push_sel_o,
   input wire logic        pop_o,
   input wire logic [1:0]  pop_sel_o,
   input wire logic        pc_load_o,
   input wire logic [15:0] program_counter_o,
   input wire logic        cpu_ce_o,
   input wire logic        slow_wait_o,
   input wire logic        wake_o,
   input wire logic        wake_osc_en_o,
   input wire logic        wake_osc_capture_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] gap_reg;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   ////////////////////////////////////////////////////////////////
   // cycles since the last cpu clock enable, saturating
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gap_reg <= 6'h00;
      end else if (cpu_ce_o) begin
         gap_reg <= 6'h00;
      end else if (gap_reg != 6'h3f) begin
         gap_reg <= gap_reg + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   // service entry and return sequencing
   a_reset_mask: assert property ($rose(arst_n_i) |-> mask_o)
      else $error("mask clear after reset");
   a_push_len: assert property ($rose(push_o)
      |-> push_o[*4] ##1 (!push_o && pc_load_o))
      else $error("stacking length or vector load wrong");
   a_push_order: assert property ($rose(push_o) |-> push_sel_o == 2'h0
      ##1 push_sel_o == 2'h1 ##1 push_sel_o == 2'h2 ##1 push_sel_o == 2'h3)
      else $error("stacking order wrong");
   a_entry_mask: assert property (pc_load_o |=> mask_o)
      else $error("mask not set on entry");
   a_pop_unmask: assert property ($rose(pop_o) |-> pop_o[*4] ##1 !mask_o)
      else $error("return did not clear mask");
   a_pop_order: assert property ($rose(pop_o) |-> pop_sel_o == 2'h0
      ##1 pop_sel_o == 2'h1 ##1 pop_sel_o == 2'h2 ##1 pop_sel_o == 2'h3)
      else $error("unstacking order wrong");
   a_masked_entry: assert property ($rose(push_o) && $past(mask_o) |-> $past(trap_i))
      else $error("entry while masked");
   a_trap_vec: assert property ($rose(push_o) && $past(trap_i)
      |-> ##4 (pc_load_o && program_counter_o == 16'hfffc))
      else $error("trap vector wrong");
   // clocking and wake oscillator
   a_slow_gap: assert property (gap_reg <= 6'h1f)
      else $error("cpu enable gap above 32");
   a_slow_wait: assert property (slow_wait_o |-> $past(wait_i))
      else $error("slow wait without wait");
   a_osc_cap: assert property (wake_osc_capture_o |-> wake_osc_en_o)
      else $error("capture without oscillator");

   c_entry: cover property ($rose(push_o));
   c_return: cover property ($rose(pop_o));
   c_halt_wake: cover property (halt_i && $rose(wake_o));
endmodule

bind iahw_ctrl iahw_checker u_chk (.clk_i, .arst_n_i, .trap_i, .wait_i, .halt_i, .mask_o,
   .push_o, .push_sel_o, .pop_o, .pop_sel_o, .pc_load_o, .program_counter_o, .cpu_ce_o,
   .slow_wait_o, .wake_o, .wake_osc_en_o, .wake_osc_capture_o);

`default_nettype wire

/* iahw_core_model.sv */
// iahw_core_model.sv: behavioural processor core on the far side of the controller.
// assumes the controller answers each service entry with a vector load pulse.
`default_nettype none

module iahw_core_model (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        run_i,
   input  wire logic        trap_req_i,
   input  wire logic        pc_load_i,
   input  wire logic [15:0] pc_i,
   output logic             instr_end_o,
   output logic             trap_o,
   output logic [15:0]      last_vec_o,
   output logic [3:0]       n_load_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_reg;
   logic       trap_reg;

   // an instruction ends every fourth cycle while running; a trap rides on it
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phase_reg   <= 2'h0;
         trap_reg    <= 1'b0;
         instr_end_o <= 1'b0;
         trap_o      <= 1'b0;
         last_vec_o  <= 16'h0000;
         n_load_o    <= 4'h0;
      end else begin
         phase_reg   <= phase_reg + 2'h1;
         instr_end_o <= run_i && phase_reg == 2'h3;
         trap_o      <= run_i && phase_reg == 2'h3 && (trap_reg || trap_req_i);
         trap_reg    <= (trap_reg || trap_req_i) && !(run_i && phase_reg == 2'h3);
         if (pc_load_i) begin
            last_vec_o <= pc_i;
            n_load_o   <= n_load_o + 4'h1;
         end
      end
   end
endmodule

`default_nettype wire

/* tb_top.sv */
// tb_top.sv: self-checking bench for the interrupt and halt wake-up controller.
// assumes the controller, its checker and the core model are compiled first.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, arst_n_i, we_i, cyc_i, stb_i, ack_o, run, trap_req;
   logic        instr_end_i, trap_i, return_from_handler_i, mask_set_i, mask_clr_i;
   logic        wait_i, halt_i, mask_o, pc_load_o, wake_o, cpu_ce_o, slow_wait_o;
   logic        wake_osc_en_o, wake_osc_capture_o, cap;
   logic [9:0]  adr_i;
   logic [31:0] dat_i, dat_o;
   logic [5:0]  ext_pins_i, ext_pin_en_i;
   logic [3:0]  per_set_i, per_assoc_i, n_load;
   logic [15:0] program_counter_o, last_vec;
   logic [7:0]  q;
   int          err_total, n_tests;

   iahw_ctrl #(.RC_DIV(2), .RCSTRT_NS(8)) uut (
      .clk_i, .arst_n_i, .adr_i, .dat_i, .sel_i(4'hf), .we_i, .cyc_i, .stb_i, .dat_o, .ack_o,
      .instr_end_i, .trap_i, .return_from_handler_i, .mask_set_i, .mask_clr_i, .wait_i,
      .halt_i, .mask_o, .push_o(), .push_sel_o(), .pop_o(), .pop_sel_o(), .pc_load_o,
      .program_counter_o, .wake_o, .cpu_ce_o, .slow_wait_o, .ext_pins_i, .ext_pin_en_i,
      .per_set_i, .per_assoc_i, .wake_osc_en_o, .wake_osc_capture_o);
   iahw_core_model u_core (.clk_i, .arst_n_i, .run_i(run), .trap_req_i(trap_req),
      .pc_load_i(pc_load_o), .pc_i(program_counter_o), .instr_end_o(instr_end_i),
      .trap_o(trap_i), .last_vec_o(last_vec), .n_load_o(n_load));

   initial clk_i = 1'b0;
   always #2 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////
   // comparison, bus cycle and service helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      adr_i <= {idx, 2'h0};
      we_i <= w;
      dat_i <= {24'h000000, d};
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      chk(ack_o, 16'h0001);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      bus(idx, 1'b0, 8'h00);
      chk(q, e);
   endtask
   task automatic entry(input logic [15:0] vec);
      logic [3:0] c0;
      int n;
      c0 = n_load;
      n = 0;
      while (n_load === c0 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      repeat (2) @(posedge clk_i);
      chk(last_vec, vec);
      chk(mask_o, 16'h0001);
   endtask
   task automatic ret_handler;
      return_from_handler_i <= 1'b1;
      @(posedge clk_i);
      return_from_handler_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(mask_o, 16'h0000);
   endtask
   task automatic halt_time(output int n);
      halt_i <= 1'b1;
      n = 0;
      while (wake_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      halt_i <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs;
      chk(mask_o, 16'h0001);
      chk(cpu_ce_o, 16'h0001);
      rd(8'h49, 8'hff);
      rd(8'h4a, 8'h00);
      rd(8'h38, 8'h00);
      rd(8'h40, 8'h00);
      bus(8'h49, 1'b1, 8'h00);
      rd(8'h49, 8'hff);
      bus(8'h49, 1'b1, 8'h01);
      rd(8'h49, 8'h01);
      bus(8'h4a, 1'b1, 8'h06);
      rd(8'h4a, 8'h02);
      chk(wake_osc_en_o, 16'h0001);
      cap = wake_osc_capture_o;
      repeat (2) @(posedge clk_i);
      chk(wake_osc_capture_o, 16'(!cap));
      bus(8'h4a, 1'b1, 8'h00);
      chk(wake_osc_en_o, 16'h0000);
      chk(wake_osc_capture_o, 16'h0000);
   endtask
   task automatic t_trap;
      run <= 1'b1;
      trap_req <= 1'b1;
      @(posedge clk_i);
      trap_req <= 1'b0;
      entry(16'hfffc);
      run <= 1'b0;
      ret_handler;
   endtask
   task automatic t_ext;
      mask_set_i <= 1'b1;
      @(posedge clk_i);
      mask_set_i <= 1'b0;
      bus(8'h3f, 1'b1, 8'h01);
      ext_pin_en_i <= 6'h03;
      ext_pins_i <= 6'h01;
      repeat (3) @(posedge clk_i);
      rd(8'h3d, 8'h80);
      ext_pins_i <= 6'h03;
      bus(8'h3e, 1'b1, 8'h01);
      per_set_i <= 4'h1;
      @(posedge clk_i);
      per_set_i <= 4'h0;
      rd(8'h3d, 8'h91);
      mask_clr_i <= 1'b1;
      @(posedge clk_i);
      mask_clr_i <= 1'b0;
      run <= 1'b1;
      entry(16'hfffa);
      rd(8'h3d, 8'h81);
      ret_handler;
      entry(16'hfff2);
      bus(8'h3d, 1'b1, 8'h00);
      rd(8'h3d, 8'h80);
      ret_handler;
      per_set_i <= 4'h2;
      @(posedge clk_i);
      per_set_i <= 4'h0;
      rd(8'h3d, 8'h02);
      per_assoc_i <= 4'h2;
      @(posedge clk_i);
      per_assoc_i <= 4'h0;
      rd(8'h3d, 8'h00);
      run <= 1'b0;
      chk(n_load, 16'h0003);
   endtask
   task automatic t_slow;
      int n;
      bus(8'h38, 1'b1, 8'h01);
      wait_i <= 1'b1;
      n = 0;
      repeat (64) begin
         @(posedge clk_i);
         n += cpu_ce_o;
      end
      chk(n[15:0], 16'h0002);
      chk(slow_wait_o, 16'h0001);
      chk(wake_o, 16'h0000);
      wait_i <= 1'b0;
      bus(8'h38, 1'b1, 8'h00);
      @(posedge clk_i);
      chk(cpu_ce_o, 16'h0001);
   endtask
   task automatic t_halt;
      int n;
      bus(8'h4a, 1'b1, 8'h01);
      halt_time(n);
      chk(16'(n >= 129 && n <= 135), 16'h0001);
      rd(8'h4a, 8'h05);
      rd(8'h4a, 8'h01);
      wait_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(wake_o, 16'h0001);
      wait_i <= 1'b0;
      run <= 1'b1;
      entry(16'hfff4);
      run <= 1'b0;
      ret_handler;
      halt_i <= 1'b1;
      repeat (60) @(posedge clk_i);
      halt_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      halt_time(n);
      chk(16'(n >= 129 && n <= 135), 16'h0001);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // watchdog
   initial begin
      #20000;
      err_total++;
      print_verdict;
   end

   initial begin
      {arst_n_i, we_i, cyc_i, stb_i, run, trap_req, wait_i, halt_i} = '0;
      {return_from_handler_i, mask_set_i, mask_clr_i, per_set_i, per_assoc_i} = '0;
      {adr_i, dat_i, ext_pins_i, ext_pin_en_i} = '0;
      err_total = 0;
      n_tests = 0;
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      t_regs;
      t_trap;
      t_ext;
      t_slow;
      t_halt;
      print_verdict;
   end
endmodule

`default_nettype wire
